/* File: sim/link_tx_csr_slave_port_tb_top.sv */
// Testbench for the register port: map, access kinds and ordering paths.
// Assumes the bound checker and the bus master model beside it.
`timescale 1ns/1ps
`default_nettype none
module link_tx_csr_slave_port_tb_top
  import ltc_pkg::*;
;
  logic        clk = 1'b0;                    // 40 MHz register clock
  logic        rst;                           // Synchronous reset
  logic [7:0]  addr;                          // Bus lines from master
  logic        rd, wr, rvalid, wreq;          // Strobes and answers
  logic [31:0] wdata, rdata, link, link_ord;  // Data words
  logic        evt_rc, evt_w1c, req_done;     // Hardware events
  logic [3:0]  live;                          // Live status
  logic        spare, sw_req;                 // Control outputs
  logic [19:0] pma, pma_ord, mir;             // Parallel words
  int          fail_count = 0;                // Mismatches
  int          compares = 0;                  // Comparisons made
  int          m_spare, m_rc, m_w1c, m_w1s;   // Model of stored bits
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  // Design, master model
  ltc_csr_port uut (.REF_CLK(clk), .RESET(rst), .ADDRESS(addr), .READ(rd), .WRITE(wr),
    .WRITEDATA(wdata), .READDATA(rdata), .READDATAVALID(rvalid), .WAITREQUEST(wreq),
    .EVT_RDCLR(evt_rc), .EVT_W1C(evt_w1c), .REQ_DONE(req_done), .LIVE_STATUS(live),
    .LANE_SPARE(spare), .SW_REQUEST(sw_req), .LINK_DATA(link), .PMA_DATA(pma),
    .LINK_DATA_ORD(link_ord), .PMA_DATA_ORD(pma_ord));
  ltc_bus_master mst (.clk(clk), .rdata(rdata), .rvalid(rvalid), .addr(addr), .rd(rd),
    .wr(wr), .wdata(wdata));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and close
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Expected word from the model
  function automatic logic [31:0] exp_word(input logic [7:0] a);
    if (a == LTC_IDX_COMMON) return {29'h0000_0000, 1'(m_spare), 2'h3};
    if (a == LTC_IDX_EVENT) return {24'h00_0000, live, 1'h0, 1'(m_w1s), 1'(m_w1c), 1'(m_rc)};
    return LTC_ZERO_WORD;
  endfunction
  // Read and compare; a read of the event word clears its read-clear bit
  task automatic rchk(input logic [7:0] a);
    logic [31:0] d;
    logic        v;
    logic [31:0] e;
    e = exp_word(a);
    mst.rd_word(a, d, v);
    chk(32'(v), 32'h0000_0001);
    chk(32'(wreq), 32'h0000_0000);
    chk(d, e);
    if (a == LTC_IDX_EVENT) m_rc = 0;
  endtask
  // Write and update the model
  task automatic wmod(input logic [7:0] a, input logic [31:0] d);
    mst.wr_word(a, d);
    if (a == LTC_IDX_COMMON) m_spare = d[LTC_BIT_SPARE];
    if (a == LTC_IDX_EVENT && d[LTC_BIT_W1C]) m_w1c = 0;
    if (a == LTC_IDX_EVENT && d[LTC_BIT_W1S]) m_w1s = 1;
  endtask
  // One-cycle hardware event: 0 read-clear set, 1 write-one-clear set, 2 request done
  task automatic pulse(input int k);
    @(negedge clk);
    {req_done, evt_w1c, evt_rc} = 3'(1 << k);
    @(negedge clk);
    {req_done, evt_w1c, evt_rc} = 3'h0;
    if (k == 0) m_rc = 1;
    else if (k == 1) m_w1c = 1;
    else m_w1s = 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    {evt_rc, evt_w1c, req_done, live, link, pma} = 59'h000_0000_0000_0000;
    {m_spare, m_rc, m_w1c, m_w1s} = 128'h0;
    void'($urandom(32'hdc44c4dc));
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    rchk(LTC_IDX_COMMON);
    rchk(LTC_IDX_EVENT);
    for (int i = 0; i < 6; i++) begin
      live = 4'($urandom);
      wmod(LTC_IDX_COMMON, $urandom);
      chk(32'(spare), 32'(m_spare));
      rchk(LTC_IDX_COMMON);
      wmod(8'($urandom_range(255, 2)), $urandom);
      rchk(8'($urandom_range(255, 2)));
      rchk(LTC_IDX_EVENT);
    end
    pulse(0);
    rchk(LTC_IDX_EVENT);
    rchk(LTC_IDX_EVENT);
    pulse(1);
    wmod(LTC_IDX_EVENT, 32'h0000_0000);
    rchk(LTC_IDX_EVENT);
    fork pulse(1); mst.wr_word(LTC_IDX_EVENT, 32'h0000_0002); join
    m_w1c = 0;
    rchk(LTC_IDX_EVENT);
    wmod(LTC_IDX_EVENT, 32'h0000_0004);
    chk(32'(sw_req), 32'h0000_0001);
    pulse(2);
    chk(32'(sw_req), 32'h0000_0000);
    fork pulse(2); mst.wr_word(LTC_IDX_EVENT, 32'h0000_0004); join
    m_w1s = 1;
    rchk(LTC_IDX_EVENT);
    for (int i = 0; i < 8; i++) begin
      link = $urandom;
      pma = 20'($urandom);
      for (int j = 0; j < 20; j++) mir[j] = pma[19-j];
      @(negedge clk);
      chk(link_ord, {link[7:0], link[15:8], link[23:16], link[31:24]});
      chk(32'(pma_ord), 32'(mir));
    end
    end_sim();
  end
  // Watchdog against a hang
  initial begin
    #(25 * 4000);
    fail_count++;
    end_sim();
  end
endmodule
`default_nettype wire

/* File: sim/ltc_bus_master.sv */
// Bus master model: word-addressed, single-beat reads and writes.
// Assumes fixed slave timing: write taken at one edge, read data two edges on.
`timescale 1ns/1ps
`default_nettype none
module ltc_bus_master (
  input  wire logic        clk,               // Register clock
  input  wire logic [31:0] rdata,             // Read data from slave
  input  wire logic        rvalid,            // Read data qualifier
  output var  logic [7:0]  addr,              // Word address, byte offset over four
  output var  logic        rd,                // Read strobe
  output var  logic        wr,                // Write strobe
  output var  logic [31:0] wdata              // Full-word write data
);
  // Idle lines at time zero
  initial begin
    {addr, wdata, wr, rd} = 42'h000_0000_0000;
  end
  // Whole-word write, one cycle; released lines show inverted values
  task automatic wr_word(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    {addr, wdata, wr, rd} <= {a, d, 2'h2};
    @(negedge clk);
    {addr, wdata, wr} <= {~a, ~d, 1'h0};
  endtask
  // Read held through its wait cycle, data taken in the valid cycle
  task automatic rd_word(input logic [7:0] a, output logic [31:0] d, output logic v);
    @(negedge clk);
    {addr, wr, rd} <= {a, 2'h1};
    repeat (2) @(negedge clk);
    d = rdata;
    v = rvalid;
    {addr, rd} <= {~a, 1'h0};
  endtask
endmodule
`default_nettype wire

/* File: sim/ltc_csr_port_asserts.sv */
// Checker for the register port: read timing, word map and ordering paths.
// Assumes one clock, REF_CLK, and a synchronous active-high RESET.
`timescale 1ns/1ps
`default_nettype none
module ltc_csr_port_asserts
  import ltc_pkg::*;
#(
  parameter int ADDR_W = LTC_ADDR_W,          // Word-address width
  parameter int PMA_W  = 20                   // Serializer word width
) (
  input wire logic                  REF_CLK,
  input wire logic                  RESET,
  input wire logic [ADDR_W-1:0]     ADDRESS,
  input wire logic                  READ,
  input wire logic                  WRITE,
  input wire logic [31:0]           WRITEDATA,
  input wire logic [31:0]           READDATA,
  input wire logic                  READDATAVALID,
  input wire logic                  WAITREQUEST,
  input wire logic                  EVT_RDCLR,
  input wire logic                  EVT_W1C,
  input wire logic                  REQ_DONE,
  input wire logic [LTC_LIVE_W-1:0] LIVE_STATUS,
  input wire logic                  LANE_SPARE,
  input wire logic                  SW_REQUEST,
  input wire logic [31:0]           LINK_DATA,
  input wire logic [PMA_W-1:0]      PMA_DATA,
  input wire logic [31:0]           LINK_DATA_ORD,
  input wire logic [PMA_W-1:0]      PMA_DATA_ORD
);
  logic [1:0]       ph_r;                     // Read phase: 0 idle, 1 wait, 2 return
  logic [1:0]       ph_nxt;                   // Next read phase
  logic             acc;                      // Read taken this cycle
  logic             sset;                     // Software set of request bit
  logic [PMA_W-1:0] mir;                      // Mirrored parallel word
  logic [31:0]      rev;                      // Octet-reversed link word
  ////////////////////////////////////////////////////////////////////////////////
  // Read phase tracking and reference copies of the ordering paths
  always_comb begin
    acc    = READ && (ph_r != 2'h1);
    ph_nxt = RESET ? 2'h0 : acc ? 2'h1 : (ph_r == 2'h1) ? 2'h2 : 2'h0;
    sset   = WRITE && !READ && ADDRESS == LTC_IDX_EVENT && WRITEDATA[LTC_BIT_W1S];
    rev    = {LINK_DATA[7:0], LINK_DATA[15:8], LINK_DATA[23:16], LINK_DATA[31:24]};
    for (int i = 0; i < PMA_W; i++) mir[i] = PMA_DATA[PMA_W-1-i];
  end
  // Phase register only
  always_ff @(posedge REF_CLK) begin
    ph_r <= ph_nxt;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Properties
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  wait_low_a: assert property (!WAITREQUEST)
    else $error("wait request raised");
  rd_pulse_a: assert property (READDATAVALID == (ph_r == 2'h2))
    else $error("read valid out of step");
  unmapped_a: assert property (acc && ADDRESS > LTC_IDX_EVENT |-> ##2 READDATA == LTC_ZERO_WORD)
    else $error("unmapped read not zero");
  common_a: assert property (acc && ADDRESS == LTC_IDX_COMMON |-> ##2
    READDATA == {29'h0000_0000, LANE_SPARE, 2'h3}) else $error("common word wrong");
  live_a: assert property (acc && ADDRESS == LTC_IDX_EVENT |-> ##2
    READDATA[31:3] == {24'h00_0000, $past(LIVE_STATUS), 1'h0}) else $error("live field wrong");
  spare_a: assert property (WRITE && !READ && ADDRESS == LTC_IDX_COMMON |=>
    LANE_SPARE == $past(WRITEDATA[LTC_BIT_SPARE])) else $error("spare bit not written");
  w1s_set_a: assert property (sset |=> SW_REQUEST)
    else $error("request bit not set");
  w1s_hold_a: assert property (!sset |=>
    SW_REQUEST == ($past(SW_REQUEST) && !$past(REQ_DONE))) else $error("request bit drift");
  link_ord_a: assert property (1'b1 |=> LINK_DATA_ORD == $past(rev))
    else $error("octet order wrong");
  pma_ord_a: assert property (1'b1 |=> PMA_DATA_ORD == $past(mir))
    else $error("bit mirror wrong");
endmodule
bind ltc_csr_port ltc_csr_port_asserts #(.ADDR_W(ADDR_W), .PMA_W(PMA_W)) u_chk (
  .REF_CLK(REF_CLK), .RESET(RESET), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
  .WRITEDATA(WRITEDATA), .READDATA(READDATA), .READDATAVALID(READDATAVALID),
  .WAITREQUEST(WAITREQUEST), .EVT_RDCLR(EVT_RDCLR), .EVT_W1C(EVT_W1C), .REQ_DONE(REQ_DONE),
  .LIVE_STATUS(LIVE_STATUS), .LANE_SPARE(LANE_SPARE), .SW_REQUEST(SW_REQUEST),
  .LINK_DATA(LINK_DATA), .PMA_DATA(PMA_DATA), .LINK_DATA_ORD(LINK_DATA_ORD),
  .PMA_DATA_ORD(PMA_DATA_ORD));
`default_nettype wire

/* File: src/ltc_csr_port.sv */
// Register slave and transmit ordering stage of the link transmitter.
// Assumes a word-addressed master on REF_CLK driving one request at a time,
// and event/status inputs produced by logic on the same clock.
//
// Notes on behaviour
// - Single-beat only; wait-request always low.
// - 32-bit data; one word per address.
// - No byte enables; writes replace whole word.
// - Write zero wait; read one wait, latency one.
// - Read-only fields ignore writes; constant or live.
// - Read-to-clear returns value, then clears it.
// - Read/write field returns stored, takes written.
// - Write-one-clear: clear beats hardware set.
// - Write-one-set: set beats hardware clear.
// - Common word bits 31:3 zero; bit 2 spare.
// - Bit 1 reports build-time serial bit order.
// - Bit-order option mirrors each parallel word.
// - Bit 0 reports octet order; reverses octets.
// - Both order options built as one.
// - Build-time fields unchanged by register writes.
`timescale 1ns/1ps
`default_nettype none
module ltc_csr_port
  import ltc_pkg::*;
#(
  parameter int   ADDR_W   = LTC_ADDR_W,           // Word-address width
  parameter int   PMA_W    = 20,                   // Serializer word width
  parameter logic BIT_REV  = 1'b1,                 // Build-time bit order
  parameter logic BYTE_REV = 1'b1                  // Build-time octet order
) (
  input  wire logic                  REF_CLK,      // Register clock, 40 MHz
  input  wire logic                  RESET,        // Synchronous, active high
  input  wire logic [ADDR_W-1:0]     ADDRESS,      // Word address
  input  wire logic                  READ,         // Read strobe
  input  wire logic                  WRITE,        // Write strobe
  input  wire logic [31:0]           WRITEDATA,    // Full-word write data
  output logic      [31:0]           READDATA,     // Read data
  output logic                       READDATAVALID, // Read data qualifier
  output logic                       WAITREQUEST,  // Always low
  input  wire logic                  EVT_RDCLR,    // Hardware event, read-clear bit
  input  wire logic                  EVT_W1C,      // Hardware event, write-one-clear bit
  input  wire logic                  REQ_DONE,     // Hardware clear of write-one-set bit
  input  wire logic [LTC_LIVE_W-1:0] LIVE_STATUS,  // Live status, same clock
  output logic                       LANE_SPARE,   // Spare control bit
  output logic                       SW_REQUEST,   // Write-one-set request bit
  input  wire logic [31:0]           LINK_DATA,    // Link word before ordering
  input  wire logic [PMA_W-1:0]      PMA_DATA,     // Parallel word before ordering
  output logic      [31:0]           LINK_DATA_ORD, // Octet-ordered link word
  output logic      [PMA_W-1:0]      PMA_DATA_ORD  // Bit-ordered parallel word
);

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks: refuse builds that the logic cannot serve
  if (PMA_W != 20 && PMA_W != 40) begin : g_bad_pma
    $error("PMA_W must be 20 or 40");
  end
  if (BIT_REV != 1'b1 || BYTE_REV != 1'b1) begin : g_bad_order
    $error("Both order options must be built as one");
  end
  if (ADDR_W < 1 || ADDR_W > 8) begin : g_bad_addr
    $error("ADDR_W must be 1 to 8");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  ltc_bus_req_s    req;                            // Packed view of the request
  ltc_rd_state_e   rd_state_r;                     // Read sequencer state
  ltc_rd_state_e   rd_state_nxt;                   // Next read state
  logic [7:0]      rd_addr_r;                      // Address latched at read accept
  logic [7:0]      rd_addr_nxt;                    // Next latched address
  logic [31:0]     rdata_r;                        // Returned read word
  logic [31:0]     rdata_nxt;                      // Next read word
  logic            rvalid_r;                       // Read data valid flag
  logic            rvalid_nxt;                     // Next valid flag
  logic            wait_r;                         // Wait-request flop
  logic            spare_r;                        // Spare control bit
  logic            spare_nxt;                      // Next spare bit
  logic [2:0]      evt_r;                          // Read-clear, W1C, W1S bits
  logic [2:0]      evt_nxt;                        // Next event bits
  logic [31:0]     link_ord;                       // Ordered link word
  logic [PMA_W-1:0] pma_ord;                       // Ordered parallel word
  logic [31:0]     link_r;                         // Registered link word
  logic [PMA_W-1:0] pma_r;                         // Registered parallel word
  logic            wr_common;                      // Write hits common word
  logic            wr_event;                       // Write hits event word
  logic            rd_fetch;                       // Read word fetched this cycle
  logic [31:0]     common_word;                    // Read view of common word
  logic [31:0]     event_word;                     // Read view of event word

  // Address widened to the package index width; master already shifted by two
  assign req.read  = READ;
  assign req.write = WRITE;
  assign req.addr  = 8'(ADDRESS);
  assign req.wdata = WRITEDATA;

  ////////////////////////////////////////////////////////////////////////////////
  // Read views of the two implemented words
  always_comb begin
    common_word                  = LTC_ZERO_WORD;
    common_word[LTC_BIT_SPARE]   = spare_r;
    common_word[LTC_BIT_BITREV]  = BIT_REV;
    common_word[LTC_BIT_BYTEREV] = BYTE_REV;
    event_word                   = LTC_ZERO_WORD;
    event_word[LTC_BIT_RDCLR]    = evt_r[0];
    event_word[LTC_BIT_W1C]      = evt_r[1];
    event_word[LTC_BIT_W1S]      = evt_r[2];
    event_word[LTC_LIVE_LSB +: LTC_LIVE_W] = LIVE_STATUS;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read sequencer: accept, one wait cycle, then one-cycle return
  always_comb begin
    rd_state_nxt = rd_state_r;
    rd_addr_nxt  = rd_addr_r;
    rdata_nxt    = rdata_r;
    rvalid_nxt   = 1'b0;
    rd_fetch     = 1'b0;
    case (rd_state_r)
      // Take a new read; a return cycle may be followed straight away
      LTC_RD_IDLE, LTC_RD_RET: begin
        if (req.read) begin
          rd_addr_nxt  = req.addr;
          rd_state_nxt = LTC_RD_WAIT;
        end else begin
          rd_state_nxt = LTC_RD_IDLE;
        end
      end
      // Master holds the read through the fixed wait; fetch the word
      LTC_RD_WAIT: begin
        rd_fetch     = 1'b1;
        rvalid_nxt   = 1'b1;
        rd_state_nxt = LTC_RD_RET;
        case (rd_addr_r)
          LTC_IDX_COMMON: rdata_nxt = common_word;
          LTC_IDX_EVENT:  rdata_nxt = event_word;
          default:        rdata_nxt = LTC_ZERO_WORD;
        endcase
      end
      default: begin
        rd_state_nxt = LTC_RD_IDLE;
      end
    endcase
  end

  // Read sequencer registers
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rd_state_r <= LTC_RD_IDLE;
      rd_addr_r  <= 8'h00;
      rdata_r    <= LTC_ZERO_WORD;
      rvalid_r   <= 1'b0;
      wait_r     <= 1'b0;
    end else begin
      rd_state_r <= rd_state_nxt;
      rd_addr_r  <= rd_addr_nxt;
      rdata_r    <= rdata_nxt;
      rvalid_r   <= rvalid_nxt;
      wait_r     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write decode: whole words only, zero wait, unmapped writes dropped
  assign wr_common = req.write && !req.read && (req.addr == LTC_IDX_COMMON);
  assign wr_event  = req.write && !req.read && (req.addr == LTC_IDX_EVENT);

  ////////////////////////////////////////////////////////////////////////////////
  // Control and event bits
  always_comb begin
    // Spare bit takes the written value; build-time bits have no storage
    spare_nxt = spare_r;
    if (wr_common) begin
      spare_nxt = req.wdata[LTC_BIT_SPARE];
    end
    evt_nxt = evt_r;
    // Read-to-clear: cleared by the fetch, a same-cycle event survives
    if (rd_fetch && rd_addr_r == LTC_IDX_EVENT) begin
      evt_nxt[0] = 1'b0;
    end
    if (EVT_RDCLR) begin
      evt_nxt[0] = 1'b1;
    end
    // Write-one-clear: hardware sets, a written one clears and wins
    if (EVT_W1C) begin
      evt_nxt[1] = 1'b1;
    end
    if (wr_event && req.wdata[LTC_BIT_W1C]) begin
      evt_nxt[1] = 1'b0;
    end
    // Write-one-set: hardware clears, a written one sets and wins
    if (REQ_DONE) begin
      evt_nxt[2] = 1'b0;
    end
    if (wr_event && req.wdata[LTC_BIT_W1S]) begin
      evt_nxt[2] = 1'b1;
    end
  end

  // Control and event registers
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      spare_r <= LTC_SPARE_RST;
      evt_r   <= LTC_EVT_RST;
    end else begin
      spare_r <= spare_nxt;
      evt_r   <= evt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit ordering stage
  ltc_lane_order #(
    .PMA_W    (PMA_W),
    .BIT_REV  (BIT_REV),
    .BYTE_REV (BYTE_REV)
  ) u_order (
    .link_in  (LINK_DATA),
    .pma_in   (PMA_DATA),
    .link_out (link_ord),
    .pma_out  (pma_ord)
  );

  // Ordered words registered toward the serializer
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      link_r <= LTC_ZERO_WORD;
      pma_r  <= '0;
    end else begin
      link_r <= link_ord;
      pma_r  <= pma_ord;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops
  assign READDATA      = rdata_r;
  assign READDATAVALID = rvalid_r;
  assign WAITREQUEST   = wait_r;
  assign LANE_SPARE    = spare_r;
  assign SW_REQUEST    = evt_r[2];
  assign LINK_DATA_ORD = link_r;
  assign PMA_DATA_ORD  = pma_r;

endmodule
`default_nettype wire

/* File: src/ltc_lane_order.sv */
// Combinational bit mirror and octet swap for the transmit path.
// Assumes the caller registers the outputs; options are fixed at build time.
`timescale 1ns/1ps
`default_nettype none
module ltc_lane_order
  import ltc_pkg::*;
#(
  parameter int   PMA_W    = 20,                   // Serializer word width, 20 or 40
  parameter logic BIT_REV  = 1'b1,                 // Mirror each serializer word
  parameter logic BYTE_REV = 1'b1                  // Reverse octets of the link word
) (
  input  wire logic [31:0]      link_in,           // Link word, octet0 in low byte
  input  wire logic [PMA_W-1:0] pma_in,            // Parallel word to serialize
  output logic      [31:0]      link_out,          // Octet-ordered link word
  output logic      [PMA_W-1:0] pma_out            // Bit-ordered parallel word
);

  ////////////////////////////////////////////////////////////////////////////////
  // Per-bit mirror: D[n-1:0] rewired to D[0:n-1] when selected
  for (genvar i = 0; i < PMA_W; i++) begin : g_mirror
    assign pma_out[i] = BIT_REV ? pma_in[PMA_W-1-i] : pma_in[i];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-octet swap: {o3,o2,o1,o0} becomes {o0,o1,o2,o3} when selected
  for (genvar k = 0; k < 4; k++) begin : g_octet
    assign link_out[8*k +: 8] = BYTE_REV ? link_in[8*(3-k) +: 8]
                                         : link_in[8*k +: 8];
  end

endmodule
`default_nettype wire

/* File: src/ltc_pkg.sv */
// Shared constants, types and register layout for the lane-control register port.
// Assumes one clock domain, synchronous active-high reset, word-addressed slave.
package ltc_pkg;

  // Bus geometry
  localparam int          LTC_DATA_W       = 32;             // Register data width
  localparam int          LTC_ADDR_W       = 8;              // Default word-address width

  // Word indices (byte offset divided by four)
  localparam logic [7:0]  LTC_IDX_COMMON   = 8'h00;          // Common lane control, byte 0x0
  localparam logic [7:0]  LTC_IDX_EVENT    = 8'h01;          // Event and status word, byte 0x4

  // Common lane control fields
  localparam int          LTC_BIT_BYTEREV  = 0;              // Octet-order build option
  localparam int          LTC_BIT_BITREV   = 1;              // Bit-order build option
  localparam int          LTC_BIT_SPARE    = 2;              // Read/write spare bit
  localparam logic        LTC_SPARE_RST    = 1'b0;           // Spare bit reset value

  // Event and status word fields
  localparam int          LTC_BIT_RDCLR    = 0;              // Read-to-clear event
  localparam int          LTC_BIT_W1C      = 1;              // Write-one-clear event
  localparam int          LTC_BIT_W1S      = 2;              // Write-one-set request
  localparam int          LTC_LIVE_LSB     = 4;              // Live status field low bit
  localparam int          LTC_LIVE_W       = 4;              // Live status field width
  localparam logic [2:0]  LTC_EVT_RST      = 3'h0;           // Event bits reset value

  // Access timing, in clock cycles
  localparam int          LTC_WRITE_WAIT   = 0;              // write_wait_cycles
  localparam int          LTC_READ_WAIT    = 1;              // read_wait_cycles
  localparam int          LTC_READ_LAT     = 1;              // read_return_latency

  // Constant words
  localparam logic [31:0] LTC_ZERO_WORD    = 32'h0000_0000;  // Unmapped read value

  // Read sequencer states, one-hot
  typedef enum logic [2:0] {
    LTC_RD_IDLE = 3'b001,                                    // No read in flight
    LTC_RD_WAIT = 3'b010,                                    // Fixed wait cycle
    LTC_RD_RET  = 3'b100                                     // Data being returned
  } ltc_rd_state_e;

  // One bus request as seen at the slave
  typedef struct packed {
    logic        read;                                       // Read strobe
    logic        write;                                      // Write strobe
    logic [7:0]  addr;                                       // Word address
    logic [31:0] wdata;                                      // Full-word write data
  } ltc_bus_req_s;

endpackage
